// >>> logic/cafl_match.sv
// One acceptance filter compared against a received identifier
`timescale 1ns/1ps
`include "cafl_params.svh"

module cafl_match (
  // Filter and selected mask contents
  input  wire logic [15:0]          filt_std_i,
  input  wire logic [15:0]          filt_ext_i,
  input  wire logic [15:0]          mask_std_i,
  input  wire logic [15:0]          mask_ext_i,
  input  wire logic                 mask_ok_i,
  input  wire logic                 enable_i,
  // Received identifier
  input  wire cafl_pkg::cafl_frame_t frame_i,
  // Result
  output logic                      hit_o
);
  import cafl_pkg::*;

  logic [10:0] sid_diff;
  logic [17:0] eid_diff;
  logic        sid_ok;
  logic        eid_ok;
  logic        type_ok;

  assign sid_diff = (frame_i.std_ident_bits ^ filt_std_i[`CAFL_SID_HI:`CAFL_SID_LO])
                  & mask_std_i[`CAFL_SID_HI:`CAFL_SID_LO];
  assign eid_diff = (frame_i.ext_ident_bits ^ {filt_std_i[`CAFL_EIDH_HI:0], filt_ext_i})
                  & {mask_std_i[`CAFL_EIDH_HI:0], mask_ext_i};
  assign sid_ok   = ~|sid_diff;
  // Standard frames carry no extended bits, so those never veto them
  assign eid_ok   = ~frame_i.ide | ~|eid_diff;
  assign type_ok  = ~mask_std_i[`CAFL_TYPE_BIT]
                  | (filt_std_i[`CAFL_TYPE_BIT] == frame_i.ide);
  // hit needs enable, id and type
  assign hit_o    = enable_i & mask_ok_i & sid_ok & eid_ok & type_ok;

endmodule : cafl_match

// >>> logic/cafl_params.svh
// Register offsets, field positions and reset values of the acceptance filter
`ifndef CAFL_PARAMS_SVH
`define CAFL_PARAMS_SVH

// Byte offsets of the register groups (one 32-bit word per register)
`define CAFL_FSTD_BASE   12'h000
`define CAFL_FEXT_BASE   12'h040
`define CAFL_MSTD_BASE   12'h080
`define CAFL_MEXT_BASE   12'h090
`define CAFL_MSEL_LO     12'h0A0
`define CAFL_MSEL_HI     12'h0A4
`define CAFL_FEN         12'h0A8
`define CAFL_BPTR_BASE   12'h0B0
`define CAFL_STATUS      12'h0C0

// Field positions inside the standard identifier registers
`define CAFL_SID_HI      15
`define CAFL_SID_LO      5
`define CAFL_TYPE_BIT    3
`define CAFL_EIDH_HI     1
`define CAFL_STD_WMASK   16'hFFEB

// Encodings
`define CAFL_MSRC_RSVD   2'h3
`define CAFL_PTR_FIFO    4'hF
`define CAFL_HSIZE_WORD  3'h2

// Reset values
`define CAFL_ID_RST      16'h0000
`define CAFL_MSEL_RST    16'h0000
`define CAFL_FEN_RST     16'hFFFF
`define CAFL_BPTR_RST    16'h0000

`endif

// >>> logic/cafl_pkg.sv
// Types shared by the acceptance filter modules
package cafl_pkg;

  // Received identifier as delivered by the protocol engine
  typedef struct packed {
    logic        ide;   // 1 = extended frame
    logic [10:0] std_ident_bits;   // std_ident_bits
    logic [17:0] ext_ident_bits;   // ext_ident_bits
  } cafl_frame_t;

  // Result handed to the receive buffer logic
  typedef struct packed {
    logic [3:0] filter;
    logic [3:0] bptr;   // hit_buffer_pointer of the winning filter
    logic       fifo;   // pointer names the receive FIFO
  } cafl_hit_t;

  // Bus slave states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_WRITE = 4'h2,
    ST_RWAIT = 4'h4,
    ST_RDATA = 4'h8
  } cafl_state_t;

endpackage : cafl_pkg

// >>> logic/cafl_prio.sv
// Lowest-numbered winner among sixteen filter hits
`timescale 1ns/1ps

module cafl_prio (
  // Per-filter hits
  input  wire logic [15:0] hits_i,
  // Winner
  output logic             any_o,
  output logic [3:0]       idx_o
);

  assign any_o = |hits_i;

  always_comb begin
    idx_o = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (hits_i[i]) begin
        idx_o = 4'(i);
      end
    end
  end

endmodule : cafl_prio

// >>> logic/cafl_top.sv
// Acceptance filter bank with its AHB-Lite register slave
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "cafl_params.svh"

module cafl_top (
  // Clock and reset
  input  wire logic                  REF_CLK_I,
  input  wire logic                  RST_B_I,
  // AHB-Lite slave
  input  wire logic                  HSEL_I,
  input  wire logic [31:0]           HADDR_I,
  input  wire logic [1:0]            HTRANS_I,
  input  wire logic                  HWRITE_I,
  input  wire logic [2:0]            HSIZE_I,
  input  wire logic [31:0]           HWDATA_I,
  input  wire logic                  HREADY_I,
  output logic      [31:0]           HRDATA_O,
  output logic                       HREADYOUT_O,
  output logic                       HRESP_O,
  // Received identifiers from the protocol engine
  input  wire logic                  RX_VALID_I,
  input  wire cafl_pkg::cafl_frame_t RX_FRAME_I,
  // Result to the receive buffer logic
  output logic                       HIT_VALID_O,
  output cafl_pkg::cafl_hit_t        HIT_O,
  output logic                       RX_REJECT_O
);
  import cafl_pkg::*;

  // Register storage
  logic [15:0] filt_std_reg [16];
  logic [15:0] filt_ext_reg [16];
  logic [15:0] mask_std_reg [3];
  logic [15:0] mask_ext_reg [3];
  logic [15:0] msel_lo_reg;
  logic [15:0] msel_hi_reg;
  logic [15:0] fen_reg;
  logic [15:0] bptr_reg     [4];

  // Bus slave state
  cafl_state_t state_reg;
  cafl_state_t state_next;
  logic [11:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic        hready_reg;

  // Result flops
  logic        hit_valid_reg;
  logic        reject_reg;
  cafl_hit_t   hit_reg;
  cafl_hit_t   hit_next;
  logic        last_acc_reg;
  logic        last_rej_reg;

  // Filtering nets
  logic [31:0] msel_all;
  logic [63:0] bptr_all;
  logic [15:0] hits;
  logic        any_hit;
  logic [3:0]  win_idx;

  // Decode nets
  logic        accept;
  logic        wr_en;
  logic        wr_fstd;
  logic        wr_fext;
  logic        wr_mstd;
  logic        wr_mext;
  logic        wr_msel_lo;
  logic        wr_msel_hi;
  logic        wr_fen;
  logic        wr_bptr;
  logic [3:0]  idx16;
  logic [1:0]  idx4;
  logic [15:0] wdata;
  logic [15:0] status;

  // Mask index for a two-bit source code; reserved code is never used
  // as an index; mask_ok_i at the comparator keeps such a filter silent,
  // so software can park a filter without touching its enable
  function automatic logic [1:0] mask_pick(input logic [1:0] src);
    mask_pick = (src == `CAFL_MSRC_RSVD) ? 2'h0 : src;
  endfunction : mask_pick

  function automatic logic [15:0] std_clean(input logic [15:0] v);
    std_clean = v & `CAFL_STD_WMASK;
  endfunction : std_clean

  // Mask registers exist only at indices 0..2
  function automatic logic mask_slot(input logic [11:0] a,
                                     input logic [11:0] base);
    mask_slot = (a[11:4] == base[11:4]) && (a[3:2] != 2'h3);
  endfunction : mask_slot

  // Read multiplexer over the whole map; unmapped words read zero
  function automatic logic [15:0] rd_mux(input logic [11:0] a);
    logic [3:0] i16;
    logic [1:0] i4;
    i16    = a[5:2];
    i4     = a[3:2];
    rd_mux = 16'h0000;
    if (a[11:6] == `CAFL_FSTD_BASE >> 6) begin
      rd_mux = filt_std_reg[i16];
    end else if (a[11:6] == `CAFL_FEXT_BASE >> 6) begin
      rd_mux = filt_ext_reg[i16];
    end else if (mask_slot(a, `CAFL_MSTD_BASE)) begin
      rd_mux = mask_std_reg[i4];
    end else if (mask_slot(a, `CAFL_MEXT_BASE)) begin
      rd_mux = mask_ext_reg[i4];
    end else if (a == `CAFL_MSEL_LO) begin
      rd_mux = msel_lo_reg;
    end else if (a == `CAFL_MSEL_HI) begin
      rd_mux = msel_hi_reg;
    end else if (a == `CAFL_FEN) begin
      rd_mux = fen_reg;
    end else if (a[11:4] == `CAFL_BPTR_BASE >> 4) begin
      rd_mux = bptr_reg[i4];
    end else if (a == `CAFL_STATUS) begin
      rd_mux = status;
    end
  endfunction : rd_mux

  // Address phase: only whole-word transfers inside the local window
  // Anything else still gets OKAY with no side effect, so a stray access
  // from a wider master cannot corrupt the filter bank
  assign accept = HSEL_I & HTRANS_I[1] & HREADY_I
                & (HSIZE_I == `CAFL_HSIZE_WORD) & (HADDR_I[31:12] == 20'h0);

  // Data phase write strobes; the write lands at the edge ending the phase
  assign wr_en      = (state_reg == ST_WRITE);
  assign idx16      = addr_reg[5:2];
  assign idx4       = addr_reg[3:2];
  assign wdata      = HWDATA_I[15:0];
  assign wr_fstd    = wr_en & (addr_reg[11:6] == `CAFL_FSTD_BASE >> 6);
  assign wr_fext    = wr_en & (addr_reg[11:6] == `CAFL_FEXT_BASE >> 6);
  assign wr_mstd    = wr_en & mask_slot(addr_reg, `CAFL_MSTD_BASE);
  assign wr_mext    = wr_en & mask_slot(addr_reg, `CAFL_MEXT_BASE);
  assign wr_msel_lo = wr_en & (addr_reg == `CAFL_MSEL_LO);
  assign wr_msel_hi = wr_en & (addr_reg == `CAFL_MSEL_HI);
  assign wr_fen     = wr_en & (addr_reg == `CAFL_FEN);
  assign wr_bptr    = wr_en & (addr_reg[11:4] == `CAFL_BPTR_BASE >> 4);

  // Reads see the last result: filter, pointer, accepted, rejected
  assign status = {6'h00, last_rej_reg, last_acc_reg,
                   hit_reg.bptr, hit_reg.filter};

  // Reads take one wait state so a read right after a write sees it
  // Writes never stall: the data lands at the edge that ends the data
  // phase, which lets a pipelined address phase overlap it safely
  always_comb begin
    state_next = ST_IDLE;
    case (state_reg)
      ST_RWAIT: state_next = ST_RDATA;
      ST_IDLE,
      ST_WRITE,
      ST_RDATA: begin
        if (accept) begin
          state_next = HWRITE_I ? ST_WRITE : ST_RWAIT;
        end
      end
      default:  state_next = ST_IDLE;
    endcase
  end

  // Bus state, address latch and answer flops
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg  <= ST_IDLE;
      addr_reg   <= 12'h000;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      state_reg  <= state_next;
      hready_reg <= (state_next != ST_RWAIT);
      if (accept) begin
        addr_reg <= HADDR_I[11:0];
      end
      if (state_reg == ST_RWAIT) begin
        hrdata_reg <= {16'h0000, rd_mux(addr_reg)};
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < 16; i++) begin
        filt_std_reg[i] <= `CAFL_ID_RST;
        filt_ext_reg[i] <= `CAFL_ID_RST;
      end
    end else begin
      if (wr_fstd) begin
        filt_std_reg[idx16] <= std_clean(wdata);
      end
      if (wr_fext) begin
        filt_ext_reg[idx16] <= wdata;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < 3; i++) begin
        mask_std_reg[i] <= `CAFL_ID_RST;
        mask_ext_reg[i] <= `CAFL_ID_RST;
      end
    end else begin
      if (wr_mstd) begin
        mask_std_reg[idx4] <= std_clean(wdata);
      end
      if (wr_mext) begin
        mask_ext_reg[idx4] <= wdata;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      msel_lo_reg <= `CAFL_MSEL_RST;
      msel_hi_reg <= `CAFL_MSEL_RST;
    end else begin
      if (wr_msel_lo) begin
        msel_lo_reg <= wdata;
      end
      if (wr_msel_hi) begin
        msel_hi_reg <= wdata;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fen_reg <= `CAFL_FEN_RST;
    end else if (wr_fen) begin
      fen_reg <= wdata;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < 4; i++) begin
        bptr_reg[i] <= `CAFL_BPTR_RST;
      end
    end else if (wr_bptr) begin
      bptr_reg[idx4] <= wdata;
    end
  end

  // Flat views: field n sits at 2n (sources) and 4n (pointers)
  assign msel_all = {msel_hi_reg, msel_lo_reg};
  assign bptr_all = {bptr_reg[3], bptr_reg[2], bptr_reg[1], bptr_reg[0]};

  // One comparator per filter, fed by the mask its source field picks
  for (genvar g = 0; g < 16; g++) begin : g_filt
    logic [1:0] msrc;
    logic [1:0] midx;
    assign msrc = msel_all[2*g +: 2];
    assign midx = mask_pick(msrc);

    cafl_match u_match (
      .filt_std_i (filt_std_reg[g]),
      .filt_ext_i (filt_ext_reg[g]),
      .mask_std_i (mask_std_reg[midx]),
      .mask_ext_i (mask_ext_reg[midx]),
      .mask_ok_i  (msrc != `CAFL_MSRC_RSVD),
      .enable_i   (fen_reg[g]),
      .frame_i    (RX_FRAME_I),
      .hit_o      (hits[g])
    );
  end

  // Priority pick among the filters that hit
  cafl_prio u_prio (
    .hits_i (hits),
    .any_o  (any_hit),
    .idx_o  (win_idx)
  );

  // route to the winner's buffer
  // On a miss the winner index is 0 and these nets are meaningless;
  // hit_reg only loads on a hit, so the status keeps the last winner
  assign hit_next.filter = win_idx;
  assign hit_next.bptr   = bptr_all[{win_idx, 2'b00} +: 4];
  assign hit_next.fifo   = (bptr_all[{win_idx, 2'b00} +: 4] == `CAFL_PTR_FIFO);

  // result pulses one cycle after the frame strobe
  // Nothing is queued here: a frame every cycle gets an answer every
  // cycle, and the buffer side must take each pulse as it comes
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      hit_valid_reg <= 1'b0;
      reject_reg    <= 1'b0;
      hit_reg       <= '0;
      last_acc_reg  <= 1'b0;
      last_rej_reg  <= 1'b0;
    end else begin
      hit_valid_reg <= RX_VALID_I & any_hit;
      reject_reg    <= RX_VALID_I & ~any_hit;
      if (RX_VALID_I) begin
        last_acc_reg <= any_hit;
        last_rej_reg <= ~any_hit;
      end
      // Held after a reject so the status keeps the last winner
      if (RX_VALID_I & any_hit) begin
        hit_reg <= hit_next;
      end
    end
  end

  // Outputs straight from flops; errors are never signalled
  // HRESP_O is a constant OKAY; the bus has no error case to report
  assign HRDATA_O    = hrdata_reg;
  assign HREADYOUT_O = hready_reg;
  assign HRESP_O     = 1'b0;
  assign HIT_VALID_O = hit_valid_reg;
  assign HIT_O       = hit_reg;
  assign RX_REJECT_O = reject_reg;

endmodule : cafl_top

// >>> sim/cafl_rx_model.sv
// Protocol engine and buffer side stand-in on the filter link
`timescale 1ns/1ps
module cafl_rx_model (
  // Clock
  input  wire logic                clk_i,
  // Frames towards the filter
  output logic                     rx_valid_o,
  output cafl_pkg::cafl_frame_t    rx_frame_o,
  // Answers from the filter
  input  wire logic                hit_valid_i,
  input  wire cafl_pkg::cafl_hit_t hit_i,
  input  wire logic                reject_i
);
  import cafl_pkg::*;
  logic [10:0] res_q[$];
  initial begin
    rx_valid_o = 1'b0;
    rx_frame_o = '0;
  end
  // One frame for one cycle; calls chain back to back
  task automatic send(input cafl_frame_t f);
    rx_valid_o <= 1'b1;
    rx_frame_o <= f;
    @(posedge clk_i);
  endtask : send
  // Idle lines carry no frame, so show garbage, not the last one
  task automatic idle();
    rx_valid_o <= 1'b0;
    rx_frame_o <= ~rx_frame_o;
  endtask : idle
  // Buffer side logs answers as {reject, valid, hit}
  always @(posedge clk_i) begin
    if (hit_valid_i || reject_i) begin
      res_q.push_back({reject_i, hit_valid_i, hit_i});
    end
  end
endmodule : cafl_rx_model

// >>> sim/cafl_top_sva.sv
// Port-level checks for the acceptance filter top
`timescale 1ns/1ps
module cafl_top_sva (
  // Clock and reset
  input wire logic                REF_CLK_I,
  input wire logic                RST_B_I,
  // Register bus
  input wire logic                HSEL_I,
  input wire logic [31:0]         HADDR_I,
  input wire logic [1:0]          HTRANS_I,
  input wire logic                HWRITE_I,
  input wire logic [2:0]          HSIZE_I,
  input wire logic                HREADY_I,
  input wire logic [31:0]         HRDATA_O,
  input wire logic                HREADYOUT_O,
  input wire logic                HRESP_O,
  // Filter link
  input wire logic                RX_VALID_I,
  input wire cafl_pkg::cafl_hit_t HIT_O,
  input wire logic                HIT_VALID_O,
  input wire logic                RX_REJECT_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Transfer taken by the slave
  wire logic take;
  assign take = HSEL_I && HTRANS_I[1] && HREADY_I && (HSIZE_I == 3'h2)
              && (HADDR_I[31:12] == 20'h0);
  a_resp_okay: assert property (HRESP_O == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (take && !HWRITE_I |=>
    !HREADYOUT_O ##1 HREADYOUT_O) else $error("read wait state wrong");
  a_write_nowait: assert property (take && HWRITE_I |=> HREADYOUT_O)
    else $error("write data phase stalled");
  a_rdata_hold: assert property (HREADYOUT_O && $past(HREADYOUT_O)
    |-> $stable(HRDATA_O)) else $error("read data moved");
  a_upper_zero: assert property (HRDATA_O[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_one_answer: assert property (RX_VALID_I |=>
    HIT_VALID_O ^ RX_REJECT_O) else $error("frame not answered once");
  a_no_spurious: assert property (!RX_VALID_I |=>
    !HIT_VALID_O && !RX_REJECT_O) else $error("answer without frame");
  a_hit_hold: assert property (!HIT_VALID_O |->
    HIT_O == $past(HIT_O)) else $error("hit result changed idle");
  a_fifo_flag: assert property (HIT_VALID_O |->
    HIT_O.fifo == (HIT_O.bptr == 4'hF)) else $error("fifo flag wrong");
  // Main scenarios reached
  c_fifo: cover property (HIT_VALID_O && HIT_O.fifo);
  c_reject: cover property (RX_REJECT_O);
  c_read: cover property (take && !HWRITE_I);
  c_b2b: cover property (RX_VALID_I [*2]);
endmodule : cafl_top_sva

bind cafl_top cafl_top_sva chk (
  .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .HSEL_I(HSEL_I),
  .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
  .HSIZE_I(HSIZE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .RX_VALID_I(RX_VALID_I), .HIT_O(HIT_O), .HIT_VALID_O(HIT_VALID_O),
  .RX_REJECT_O(RX_REJECT_O)
);

// >>> sim/tb.sv
// Self-checking bench for the acceptance filter
`timescale 1ns/1ps
module tb;
  import cafl_pkg::*;
  logic             ref_clk = 1'b0;
  logic             rst_b   = 1'b0;
  logic             hsel    = 1'b0;
  logic [31:0]      haddr   = 32'h0;
  logic [1:0]       htrans  = 2'h0;
  logic             hwrite  = 1'b0;
  logic [2:0]       hsize   = 3'h2;
  logic [31:0]      hwdata  = 32'h0;
  logic [31:0]      rd;
  logic [10:0]      r;
  logic [10:0]      e;
  wire logic [31:0] hrdata;
  wire logic        hready;
  wire logic        hresp;
  wire logic        rx_valid;
  wire cafl_frame_t rx_frame;
  wire logic        hit_valid;
  wire cafl_hit_t   hit;
  wire logic        reject;
  int               err_total = 0;
  int               cmp_count = 0;
  // Setup writes: masks, filters, mask select, enables, pointers
  logic [11:0] ca[17] = '{12'h080, 12'h090, 12'h084, 12'h094, 12'h088,
    12'h098, 12'h000, 12'h004, 12'h044, 12'h008, 12'h048, 12'h028,
    12'h0A0, 12'h0A4, 12'h0A8, 12'h0B0, 12'h0BC};
  logic [15:0] cd[17] = '{16'hFFCB, 16'hFFFE, 16'h0, 16'h0, 16'hFFE3,
    16'hFFFF, 16'h2460, 16'h246B, 16'h4567, 16'hFFE8, 16'h0, 16'h0,
    16'h0020, 16'h4070, 16'h8407, 16'h0765, 16'hF000};
  // Frames and expected {filter, pointer}; filter 16 means reject
  cafl_frame_t fr[13] = '{30'h048C0000, 30'h04880000, 30'h248F4567,
    30'h248F4566, 30'h248F4565, 30'h248E4567, 30'h1FFC0000, 30'h3FFC0000,
    30'h3FFD0000, 30'h04900000, 30'h0, 30'h048C0000, 30'h3FFC0000};
  logic [8:0] ex[13] = '{9'h005, 9'h005, 9'h016, 9'h016, 9'h0FF, 9'h0FF,
    9'h027, 9'h027, 9'h0FF, 9'h0FF, 9'h100, 9'h005, 9'h027};

  always #20 ref_clk = ~ref_clk;

  cafl_top uut (.REF_CLK_I(ref_clk), .RST_B_I(rst_b), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .RX_VALID_I(rx_valid), .RX_FRAME_I(rx_frame),
    .HIT_VALID_O(hit_valid), .HIT_O(hit), .RX_REJECT_O(reject));
  cafl_rx_model eng (.clk_i(ref_clk), .rx_valid_o(rx_valid),
    .rx_frame_o(rx_frame), .hit_valid_i(hit_valid), .hit_i(hit),
    .reject_i(reject));

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask : check

  // Ready and read data are taken at the rising edge itself; the slave's
  // flops still show their pre-edge values there, as the bus samples them
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1 && n < 50) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 50) begin
      err_total++;
      $display("wrong value at %0t: bus answer timed out", $time);
      wrap_up();
    end
    rd = hrdata;
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [15:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    wait_rdy();
  endtask : bus

  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    bus(1'b0, a, 16'h0);
    check(rd, x);
  endtask : rchk

  // Frames back to back, then every answer against the table
  task automatic run(input int lo, input int hi);
    eng.res_q.delete();
    for (int i = lo; i < hi; i++) eng.send(fr[i]);
    eng.idle();
    repeat (2) @(posedge ref_clk);
    check(eng.res_q.size(), hi - lo);
    for (int i = lo; i < hi && i - lo < eng.res_q.size(); i++) begin
      r = eng.res_q[i - lo];
      e = {1'b0, 1'b1, ex[i][7:0], ex[i][3:0] == 4'hF};
      if (ex[i][8]) begin
        check(r[10:9], 2'b10);
      end else begin
        check(r, e);
      end
    end
  endtask : run

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    rchk(12'h0A0, 32'h0);
    rchk(12'h0A4, 32'h0);
    rchk(12'h0A8, 32'hFFFF);
    bus(1'b1, 12'h080, 16'hFFFF);
    rchk(12'h080, 32'hFFEB);
    bus(1'b1, 12'h03C, 16'hFFFF);
    rchk(12'h03C, 32'hFFEB);
    rchk(12'h0FC, 32'h0);
    for (int i = 0; i < 17; i++) bus(1'b1, ca[i], cd[i]);
    rchk(12'h0A4, 32'h4070);
    rchk(12'h044, 32'h4567);
    run(0, 10);
    // Drop the catch-all filter so an unmatched frame is refused
    bus(1'b1, 12'h0A8, 16'h0407);
    run(10, 13);
    // Status keeps the last winner: filter 2, pointer 7, accepted
    rchk(12'h0C0, 32'h0172);
    wrap_up();
  end
endmodule : tb
